// ==== ccs_top.sv ====
/*
 cache control and status register logic for an instruction and a data cache.
 assumes the integer unit and cache arrays sit on the same clock; flush done
 and parity error strobes are one-cycle pulses from that logic.
*/
// Design decisions made here: the register offsets and the plain strobed port.
`include "ccs_defs.svh"
`timescale 1ns/1ps
`default_nettype none
module ccs_top (
   input  wire logic                   clk,
   input  wire logic                   rst,
   input  wire logic [`CCS_ADDR_W-1:0] addr,
   input  wire logic [31:0]            wdata,
   input  wire logic                   wr,
   input  wire logic                   rd,
   output logic [31:0]                 rdata,
   input  wire logic                   irq_taken,
   input  wire logic                   iflush_done,
   input  wire logic                   dflush_done,
   input  wire logic                   err_itag,
   input  wire logic                   err_idata,
   input  wire logic                   err_dtag,
   input  wire logic                   err_ddata,
   output logic                        dcache_snoop_enable,
   output logic                        instr_burst_fill,
   output logic [1:0]                  parity_test_bits,
   output logic                        icache_flush_start,
   output logic                        dcache_flush_start,
   output logic                        icache_flush_pending,
   output logic                        dcache_flush_pending,
   output logic                        icache_hit_serve,
   output logic                        icache_allocate,
   output logic                        dcache_hit_serve,
   output logic                        dcache_allocate
);
   ccs_pkg::ccs_state_t st_ff;
   ccs_pkg::ccs_state_t nxt_st;

   logic [31:0] ctrl_view;
   logic        wr_ctrl;

   function automatic logic [1:0] ccs_count(input logic [1:0] cur, input logic ev);
      if (ev && cur != `CCS_CNT_SAT)
         ccs_count = cur + `CCS_CNT_ONE;
      else
         ccs_count = cur;
   endfunction

   always_comb begin
      ctrl_view = '0;
      ctrl_view[`CCS_DREPL_LSB +: 2] = `CCS_REPL_LRU;
      ctrl_view[`CCS_IREPL_LSB +: 2] = `CCS_REPL_LRU;
      ctrl_view[`CCS_ISETS_LSB +: 2] = `CCS_ISETS_FOUR;
      ctrl_view[`CCS_DSETS_LSB +: 2] = `CCS_DSETS_TWO;
      ctrl_view[`CCS_SNOOP_BIT]      = st_ff.snoop;
      ctrl_view[`CCS_CPC_LSB +: 2]   = `CCS_CPC_TWO;
      ctrl_view[`CCS_CPTB_LSB +: 2]  = st_ff.cptb;
      ctrl_view[`CCS_IB_BIT]         = st_ff.ib;
      ctrl_view[`CCS_IP_BIT]         = (st_ff.ifl == ccs_pkg::CCS_BUSY);
      ctrl_view[`CCS_DP_BIT]         = (st_ff.dfl == ccs_pkg::CCS_BUSY);
      ctrl_view[`CCS_ITE_LSB +: 2]   = st_ff.ite;
      ctrl_view[`CCS_IDE_LSB +: 2]   = st_ff.ide;
      ctrl_view[`CCS_DTE_LSB +: 2]   = st_ff.dte;
      ctrl_view[`CCS_DDE_LSB +: 2]   = st_ff.dde;
      ctrl_view[`CCS_DF_BIT]         = st_ff.dfrz;
      ctrl_view[`CCS_IF_BIT]         = st_ff.ifrz;
      ctrl_view[`CCS_DCS_LSB +: 2]   = st_ff.dcs;
      ctrl_view[`CCS_ICS_LSB +: 2]   = st_ff.ics;
   end

   assign wr_ctrl = wr && (addr == `CCS_OFF_CTRL);

   always_comb begin
      nxt_st = st_ff;
      nxt_st.ifl_start = 1'b0;
      nxt_st.dfl_start = 1'b0;
      if (wr_ctrl) begin
         nxt_st.snoop = wdata[`CCS_SNOOP_BIT];
         nxt_st.ib    = wdata[`CCS_IB_BIT];
         nxt_st.cptb  = wdata[`CCS_CPTB_LSB +: 2];
         nxt_st.dfrz  = wdata[`CCS_DF_BIT];
         nxt_st.ifrz  = wdata[`CCS_IF_BIT];
         nxt_st.dcs   = wdata[`CCS_DCS_LSB +: 2];
         nxt_st.ics   = wdata[`CCS_ICS_LSB +: 2];
         nxt_st.ite   = wdata[`CCS_ITE_LSB +: 2];
         nxt_st.ide   = wdata[`CCS_IDE_LSB +: 2];
         nxt_st.dte   = wdata[`CCS_DTE_LSB +: 2];
         nxt_st.dde   = wdata[`CCS_DDE_LSB +: 2];
      end
      // an error in the write cycle still counts on top of the written value
      nxt_st.ite = ccs_count(nxt_st.ite, err_itag);
      nxt_st.ide = ccs_count(nxt_st.ide, err_idata);
      nxt_st.dte = ccs_count(nxt_st.dte, err_dtag);
      nxt_st.dde = ccs_count(nxt_st.dde, err_ddata);
      // freeze only from enabled: a disabled cache stays bypassed
      if (irq_taken && st_ff.dfrz && nxt_st.dcs == `CCS_ST_ENABLED)
         nxt_st.dcs = `CCS_ST_FROZEN;
      if (irq_taken && st_ff.ifrz && nxt_st.ics == `CCS_ST_ENABLED)
         nxt_st.ics = `CCS_ST_FROZEN;
      // flush pending: done ends it, a new request in the same cycle restarts it
      if (st_ff.ifl == ccs_pkg::CCS_BUSY && iflush_done)
         nxt_st.ifl = ccs_pkg::CCS_IDLE;
      if (st_ff.dfl == ccs_pkg::CCS_BUSY && dflush_done)
         nxt_st.dfl = ccs_pkg::CCS_IDLE;
      if (wr_ctrl && wdata[`CCS_FI_BIT]) begin
         nxt_st.ifl = ccs_pkg::CCS_BUSY;
         nxt_st.ifl_start = 1'b1;
      end
      if (wr_ctrl && wdata[`CCS_FD_BIT]) begin
         nxt_st.dfl = ccs_pkg::CCS_BUSY;
         nxt_st.dfl_start = 1'b1;
      end
      nxt_st.rdata = '0;
      if (rd) begin
         case (addr)
            `CCS_OFF_CTRL:   nxt_st.rdata = ctrl_view;
            `CCS_OFF_FLSTAT: begin
               nxt_st.rdata[`CCS_IP_BIT] = ctrl_view[`CCS_IP_BIT];
               nxt_st.rdata[`CCS_DP_BIT] = ctrl_view[`CCS_DP_BIT];
            end
            default:         nxt_st.rdata = '0;
         endcase
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         st_ff <= '{snoop: 1'b0, ib: 1'b0, cptb: `CCS_ZERO2, dfrz: 1'b0, ifrz: 1'b0,
                    dcs: `CCS_ST_DISABLED, ics: `CCS_ST_DISABLED, ite: `CCS_ZERO2,
                    ide: `CCS_ZERO2, dte: `CCS_ZERO2, dde: `CCS_ZERO2,
                    ifl: ccs_pkg::CCS_IDLE, dfl: ccs_pkg::CCS_IDLE,
                    ifl_start: 1'b0, dfl_start: 1'b0, rdata: 32'h0000_0000};
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign rdata                = st_ff.rdata;
   assign dcache_snoop_enable  = st_ff.snoop;
   assign instr_burst_fill     = st_ff.ib;
   assign parity_test_bits     = st_ff.cptb;
   assign icache_flush_start   = st_ff.ifl_start;
   assign dcache_flush_start   = st_ff.dfl_start;
   assign icache_flush_pending = (st_ff.ifl == ccs_pkg::CCS_BUSY);
   assign dcache_flush_pending = (st_ff.dfl == ccs_pkg::CCS_BUSY);
   // low bit zero is disabled whatever the high bit holds
   assign icache_hit_serve     = st_ff.ics[0];
   assign icache_allocate      = (st_ff.ics == `CCS_ST_ENABLED);
   assign dcache_hit_serve     = st_ff.dcs[0];
   assign dcache_allocate      = (st_ff.dcs == `CCS_ST_ENABLED);

   a_sat_no_wrap: assert property (@(posedge clk) disable iff (rst)
      (st_ff.ite == `CCS_CNT_SAT && !wr_ctrl) |=> st_ff.ite == `CCS_CNT_SAT)
      else $error("tag error counter wrapped");
   a_cnt_incr: assert property (@(posedge clk) disable iff (rst)
      (err_dtag && !wr_ctrl && st_ff.dte != `CCS_CNT_SAT) |=> st_ff.dte == $past(st_ff.dte) + `CCS_CNT_ONE)
      else $error("data tag counter missed an error");
   a_dflush_pend: assert property (@(posedge clk) disable iff (rst)
      (wr_ctrl && wdata[`CCS_FD_BIT]) |=> dcache_flush_pending && dcache_flush_start)
      else $error("data flush not started");
   a_iflush_hold: assert property (@(posedge clk) disable iff (rst)
      (icache_flush_pending && !iflush_done && !wr_ctrl) |=> icache_flush_pending)
      else $error("instruction flush pending dropped early");
   a_dpend_clear: assert property (@(posedge clk) disable iff (rst)
      (dcache_flush_pending && dflush_done && !(wr_ctrl && wdata[`CCS_FD_BIT])) |=> !dcache_flush_pending)
      else $error("data flush pending not cleared");
   a_fixed_fields: assert property (@(posedge clk) disable iff (rst)
      (rd && addr == `CCS_OFF_CTRL) |=> rdata[31:24] == {`CCS_REPL_LRU, `CCS_REPL_LRU, `CCS_ISETS_FOUR, `CCS_DSETS_TWO}
      && rdata[20:19] == `CCS_CPC_TWO
      && !rdata[`CCS_FD_BIT] && !rdata[`CCS_FI_BIT])
      else $error("fixed fields read wrong");
   a_dfreeze_irq: assert property (@(posedge clk) disable iff (rst)
      (irq_taken && st_ff.dfrz && st_ff.dcs == `CCS_ST_ENABLED && !wr_ctrl) |=> st_ff.dcs == `CCS_ST_FROZEN)
      else $error("data cache not frozen on interrupt");
   a_ifreeze_irq: assert property (@(posedge clk) disable iff (rst)
      (irq_taken && st_ff.ifrz && st_ff.ics == `CCS_ST_ENABLED && !wr_ctrl) |=> !icache_allocate && icache_hit_serve)
      else $error("instruction cache not frozen on interrupt");
   a_snoop_follow: assert property (@(posedge clk) disable iff (rst)
      wr_ctrl |=> dcache_snoop_enable == $past(wdata[`CCS_SNOOP_BIT]))
      else $error("snoop enable not written");
   a_burst_follow: assert property (@(posedge clk) disable iff (rst)
      wr_ctrl |=> instr_burst_fill == $past(wdata[`CCS_IB_BIT]))
      else $error("burst enable not written");
endmodule // ccs_top
`default_nettype wire

// ==== ccs_defs.svh ====
/*
 cache control register constants: field positions, fixed values, reset values.
 assumes inclusion by bare name from the cache control design files.
*/
`ifndef CCS_DEFS_SVH
`define CCS_DEFS_SVH
`define CCS_ADDR_W        4
`define CCS_OFF_CTRL      4'h0
`define CCS_OFF_FLSTAT    4'h4
`define CCS_DREPL_LSB     30
`define CCS_IREPL_LSB     28
`define CCS_ISETS_LSB     26
`define CCS_DSETS_LSB     24
`define CCS_SNOOP_BIT     23
`define CCS_FD_BIT        22
`define CCS_FI_BIT        21
`define CCS_CPC_LSB       19
`define CCS_CPTB_LSB      17
`define CCS_IB_BIT        16
`define CCS_IP_BIT        15
`define CCS_DP_BIT        14
`define CCS_ITE_LSB       12
`define CCS_IDE_LSB       10
`define CCS_DTE_LSB       8
`define CCS_DDE_LSB       6
`define CCS_DF_BIT        5
`define CCS_IF_BIT        4
`define CCS_DCS_LSB       2
`define CCS_ICS_LSB       0
`define CCS_REPL_LRU      2'h3
`define CCS_ISETS_FOUR    2'h3
`define CCS_DSETS_TWO     2'h1
`define CCS_CPC_TWO       2'h2
`define CCS_CNT_SAT       2'h3
`define CCS_CNT_ONE       2'h1
`define CCS_ST_FROZEN     2'h1
`define CCS_ST_ENABLED    2'h3
`define CCS_ST_DISABLED   2'h0
`define CCS_ZERO2         2'h0
`endif

// ==== ccs_pkg.sv ====
/*
 types for the cache control and status block.
 assumes nothing beyond a SystemVerilog compiler.
*/
package ccs_pkg;
   typedef enum logic [1:0] {CCS_IDLE, CCS_BUSY} ccs_flush_t;
   typedef struct packed {
      logic       snoop;
      logic       ib;
      logic [1:0] cptb;
      logic       dfrz;
      logic       ifrz;
      logic [1:0] dcs;
      logic [1:0] ics;
      logic [1:0] ite;
      logic [1:0] ide;
      logic [1:0] dte;
      logic [1:0] dde;
      ccs_flush_t ifl;
      ccs_flush_t dfl;
      logic       ifl_start;
      logic       dfl_start;
      logic [31:0] rdata;
   } ccs_state_t;
endpackage

// ==== ccs_partner_model.sv ====
/*
 behavioural model of the integer unit and cache arrays: answers each flush
 start with a one-cycle done pulse after a fixed delay.
 assumes the same clock and reset as the cache control block.
*/
`timescale 1ns/1ps
`default_nettype none
module ccs_partner_model #(
   parameter int FLUSH_LAT = 8
) (
   input  wire logic clk,
   input  wire logic rst,
   input  wire logic icache_flush_start,
   input  wire logic dcache_flush_start,
   output logic      iflush_done,
   output logic      dflush_done
);
   logic [7:0] icnt_ff;
   logic [7:0] dcnt_ff;
   // a flush takes several cycles so pending can be seen standing
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         icnt_ff <= 8'h00;
         dcnt_ff <= 8'h00;
      end else begin
         if (icache_flush_start) icnt_ff <= 8'(FLUSH_LAT);
         else if (icnt_ff != 8'h00) icnt_ff <= icnt_ff - 8'h01;
         if (dcache_flush_start) dcnt_ff <= 8'(FLUSH_LAT);
         else if (dcnt_ff != 8'h00) dcnt_ff <= dcnt_ff - 8'h01;
      end
   end
   assign iflush_done = (icnt_ff == 8'h01);
   assign dflush_done = (dcnt_ff == 8'h01);
endmodule // ccs_partner_model
`default_nettype wire

// ==== cache_control_status_tb.sv ====
/*
 self-checking testbench for the cache control block: register tasks,
 error and interrupt pulses, flush handshakes through the partner model.
 assumes ccs_top with its register port and one 25 MHz clock.
*/
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin fail_count++; \
   $display("wrong value at %0t: got %h expected %h", $time, g, e); end end
module cache_control_status_tb;
   logic [3:0]  addr = 4'h0;
   logic [31:0] wdata = 32'h0;
   logic [31:0] rdata;
   logic        clk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0, irq = 1'b0;
   logic [3:0]  errv = 4'h0;
   logic        i_done, d_done, i_start, d_start, i_pend, d_pend;
   logic        snoop, burst, i_hit, i_alloc, d_hit, d_alloc;
   logic [1:0]  ptb;
   int          fail_count = 0, n_tests = 0, k;
   logic [31:0] fcmd [2] = '{32'h00400008, 32'h00200000};
   logic [31:0] fexp [2] = '{32'hFD104008, 32'hFD108000};

   always #20 clk = ~clk;

   ccs_top i_dut (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
      .irq_taken(irq), .iflush_done(i_done), .dflush_done(d_done), .err_itag(errv[3]),
      .err_idata(errv[2]), .err_dtag(errv[1]), .err_ddata(errv[0]), .dcache_snoop_enable(snoop),
      .instr_burst_fill(burst), .parity_test_bits(ptb), .icache_flush_start(i_start),
      .dcache_flush_start(d_start), .icache_flush_pending(i_pend), .dcache_flush_pending(d_pend),
      .icache_hit_serve(i_hit), .icache_allocate(i_alloc), .dcache_hit_serve(d_hit),
      .dcache_allocate(d_alloc));

   ccs_partner_model #(.FLUSH_LAT(8)) i_far (.clk(clk), .rst(rst), .icache_flush_start(i_start),
      .dcache_flush_start(d_start), .iflush_done(i_done), .dflush_done(d_done));

   task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
      @(posedge clk) begin addr <= a; wdata <= d; wr <= 1'b1; end
      @(posedge clk) wr <= 1'b0;
   endtask

   // read data stand only in the cycle after the strobe
   task automatic rd_chk(input logic [3:0] a, input logic [31:0] e);
      @(posedge clk) begin addr <= a; rd <= 1'b1; end
      @(posedge clk) rd <= 1'b0;
      #1 `CHK(rdata, e)
   endtask

   task automatic pulse(input logic [3:0] e, input logic q);
      @(posedge clk) begin errv <= e; irq <= q; end
      @(posedge clk) begin errv <= 4'h0; irq <= 1'b0; end
   endtask

   task automatic end_of_test;
      $display("comparisons %0d mismatches %0d", n_tests, fail_count);
      if (fail_count == 0 && n_tests > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask

   initial begin
      #200000;
      fail_count++;
      end_of_test();
   end

   initial begin
      repeat (12) @(posedge clk);
      rst <= 1'b0;
      rd_chk(4'h0, 32'hFD100000);
      $display("test reset view done");
      wr_reg(4'h0, 32'hFF9FFFFF);
      rd_chk(4'h0, 32'hFD973FFF);
      `CHK({snoop, burst, ptb}, 4'hF)
      `CHK({d_hit, d_alloc, i_hit, i_alloc}, 4'hF)
      rd_chk(4'h8, 32'h00000000);
      wr_reg(4'h8, 32'h00000000);
      rd_chk(4'h0, 32'hFD973FFF);
      $display("test write view done");
      // writing zero clears the saturated counters before new events count
      wr_reg(4'h0, 32'h0000003F);
      #1 `CHK({snoop, burst, ptb}, 4'h0)
      pulse(4'hF, 1'b0);
      pulse(4'hB, 1'b0);
      pulse(4'h9, 1'b0);
      pulse(4'h9, 1'b0);
      rd_chk(4'h0, 32'hFD1036FF);
      $display("test counters done");
      pulse(4'h0, 1'b1);
      rd_chk(4'h0, 32'hFD1036F5);
      `CHK({d_hit, d_alloc, i_hit, i_alloc}, 4'hA)
      wr_reg(4'h0, 32'h00000008);
      rd_chk(4'h0, 32'hFD100008);
      `CHK({d_hit, d_alloc, i_hit, i_alloc}, 4'h0)
      $display("test states done");
      for (int i = 0; i < 2; i++) begin
         wr_reg(4'h0, fcmd[i]);
         #1 `CHK({i_start, d_start, i_pend, d_pend}, (i == 0) ? 4'h5 : 4'hA)
         rd_chk(4'h0, fexp[i]);
         k = 0;
         while ((i_pend | d_pend) && k < 40) begin
            @(posedge clk);
            #1 k++;
         end
         #1 `CHK({i_pend, d_pend}, 2'h0)
         rd_chk(4'h0, fexp[i] & 32'hFFFF3FFF);
      end
      $display("test flushes done");
      end_of_test();
   end
endmodule // cache_control_status_tb
`undef CHK
`default_nettype wire
